// file: hw/alr_result_port.sv
// Behaviour
// - One result word is queued for every frame whose lookups completed.
// - Port has sixteen data bits, valid output, select and next inputs.
// - result_valid stays high while any result word is pending.
// - result_select enables the result bus driver; otherwise bus floats.
// - A next strobe with select high advances to the following word.
// - With words remaining, result_valid stays high within 140 ns.
// - Consuming the last word drops result_valid within 140 ns.
// - A next strobe is ignored unless result_select is high.
// - Each word leaves by exactly one path, port or host register.
// - Host result word has the same bit layout as the bus.
// - Bits 15:10 carry the receiving port.
// - Bits 9:8 give frame type: broadcast, multicast or unicast.
// - Bit 7 flags a destination match, only for unicast frames.
// - With a match, bits 6:1 give the forwarding port.
// - Bit 0 is set after a match when destination equals source.
// - A status register shows whether result words are pending.
// - Each host read of the result word returns the next word.
// - With interrupts enabled, host_interrupt_n stays low while words pend.
`timescale 1ns/1ps
module alr_result_port
  import alr_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            lookup_valid,
  input  wire alr_lookup_t     lookup_res,
  output logic                 lookup_ready,
  input  wire logic            result_select,
  input  wire logic            result_next,
  output logic [WORD_W-1:0]    result_bus_o,
  output logic                 result_bus_oe,
  output logic                 result_valid,
  input  wire alr_host_req_t   host_req,
  output logic [WORD_W-1:0]    host_rdata,
  output logic                 host_data_oe,
  output logic                 host_rdy,
  output logic                 host_interrupt_n
);

  logic [WORD_W-1:0] mem_q [DEPTH];
  logic              sel_s1_q, sel_s2_q;
  logic              nxt_s1_q, nxt_s2_q, nxt_s3_q;
  alr_host_req_t     host_s1_q, host_s2_q;
  alr_host_state_t   hst_q, hst_d;
  logic [PTR_W-1:0]  rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              irq_en_q, irq_en_d;
  logic [WORD_W-1:0] bus_q, bus_d, rdata_q, rdata_d;
  logic              valid_q, valid_d, ready_q, ready_d;
  logic              oe_q, oe_d, hoe_q, hoe_d, rdy_q, rdy_d;
  logic              irq_n_q, irq_n_d;
  logic              push, port_pop, host_pop, pop, host_act;
  alr_result_t       new_word;
  logic [WORD_W-1:0] stat_word;
  alr_result_t       bus_view;

  // Pins from the switch hardware and the host cross into core_clk here.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_s1_q  <= 1'b0;
      sel_s2_q  <= 1'b0;
      nxt_s1_q  <= 1'b0;
      nxt_s2_q  <= 1'b0;
      nxt_s3_q  <= 1'b0;
      host_s1_q <= '{cs_n: 1'b1, write_n: 1'b1, addr: 8'h00, wdata: 16'h0000};
      host_s2_q <= '{cs_n: 1'b1, write_n: 1'b1, addr: 8'h00, wdata: 16'h0000};
    end else begin
      sel_s1_q  <= result_select;
      sel_s2_q  <= sel_s1_q;
      nxt_s1_q  <= result_next;
      nxt_s2_q  <= nxt_s1_q;
      nxt_s3_q  <= nxt_s2_q;
      host_s1_q <= host_req;
      host_s2_q <= host_s1_q;
    end
  end

  always_comb begin
    // Match, forwarding port and same-port flag only mean something for
    // a unicast hit, so they read as zero otherwise.
    new_word            = '0;
    new_word.src_port   = lookup_res.src_port;
    new_word.frame_type = lookup_res.frame_type;
    new_word.da_match   = lookup_res.da_match &&
                          (lookup_res.frame_type == ALR_TYPE_UCAST);
    if (new_word.da_match) begin
      new_word.dst_port  = lookup_res.dst_port;
      new_word.same_port = (lookup_res.dst_port ==
                            lookup_res.src_port);
    end
    stat_word                              = '0;
    stat_word[STAT_CNT_LSB +: CNT_W]       = cnt_q;
    stat_word[STAT_PEND_BIT]               = (cnt_q != '0);

    push     = lookup_valid && ready_q;
    // Rising edge of next, gated by select, takes one word.
    port_pop = sel_s2_q && nxt_s2_q && !nxt_s3_q &&
               (cnt_q != '0);
    // A host access that collides with a port pop waits a cycle, so a
    // word is never handed to both paths.
    host_act = (hst_q == ALR_HOST_ACT) && !port_pop;
    host_pop = host_act && host_s2_q.write_n &&
               (host_s2_q.addr == OFF_RESULT_WORD) &&
               (cnt_q != '0);
    pop      = port_pop || host_pop;

    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    cnt_d    = cnt_q + CNT_W'(push) - CNT_W'(pop);

    hst_d    = hst_q;
    irq_en_d = irq_en_q;
    rdata_d  = rdata_q;
    case (hst_q)
      ALR_HOST_IDLE: begin
        if (!host_s2_q.cs_n) begin
          hst_d = ALR_HOST_ACT;
        end
      end
      ALR_HOST_ACT: begin
        if (host_act) begin
          hst_d = ALR_HOST_HOLD;
          if (!host_s2_q.write_n) begin
            if (host_s2_q.addr == OFF_RESULT_CTRL) begin
              irq_en_d = host_s2_q.wdata[CTRL_IRQ_BIT];
            end
          end else begin
            case (host_s2_q.addr)
              OFF_RESULT_STATUS: rdata_d = stat_word;
              OFF_RESULT_WORD:   rdata_d = (cnt_q != '0) ?
                                 mem_q[rd_ptr_q] : WORD_RST;
              OFF_RESULT_CTRL: begin
                rdata_d               = '0;
                rdata_d[CTRL_IRQ_BIT] = irq_en_q;
              end
              default:           rdata_d = '0;
            endcase
          end
        end
      end
      ALR_HOST_HOLD: begin
        if (host_s2_q.cs_n) begin
          hst_d = ALR_HOST_IDLE;
        end
      end
      default: hst_d = ALR_HOST_IDLE;
    endcase

    // The head is bypassed from the incoming word when the queue is empty,
    // since the array write lands only at the clock edge.
    if (cnt_d == '0) begin
      bus_d = WORD_RST;
    end else if (push && (rd_ptr_d == wr_ptr_q)) begin
      bus_d = new_word;
    end else begin
      bus_d = mem_q[rd_ptr_d];
    end
    valid_d = (cnt_d != '0);
    ready_d = (cnt_d != DEPTH_CNT);
    oe_d    = sel_s2_q;
    hoe_d   = (hst_d == ALR_HOST_HOLD) && host_s2_q.write_n &&
              !host_s2_q.cs_n;
    rdy_d   = (hst_d == ALR_HOST_HOLD) && !host_s2_q.cs_n;
    irq_n_d = !(irq_en_d && (cnt_d != '0));
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= new_word;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hst_q    <= ALR_HOST_IDLE;
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      cnt_q    <= '0;
      irq_en_q <= CTRL_IRQ_RST;
      bus_q    <= WORD_RST;
      rdata_q  <= WORD_RST;
      valid_q  <= 1'b0;
      ready_q  <= 1'b0;
      oe_q     <= 1'b0;
      hoe_q    <= 1'b0;
      rdy_q    <= 1'b0;
      irq_n_q  <= 1'b1;
    end else begin
      hst_q    <= hst_d;
      rd_ptr_q <= rd_ptr_d;
      wr_ptr_q <= wr_ptr_d;
      cnt_q    <= cnt_d;
      irq_en_q <= irq_en_d;
      bus_q    <= bus_d;
      rdata_q  <= rdata_d;
      valid_q  <= valid_d;
      ready_q  <= ready_d;
      oe_q     <= oe_d;
      hoe_q    <= hoe_d;
      rdy_q    <= rdy_d;
      irq_n_q  <= irq_n_d;
    end
  end

  assign result_bus_o     = bus_q;
  assign result_bus_oe    = oe_q;
  assign result_valid     = valid_q;
  assign lookup_ready     = ready_q;
  assign host_rdata       = rdata_q;
  assign host_data_oe     = hoe_q;
  assign host_rdy         = rdy_q;
  assign host_interrupt_n = irq_n_q;
  assign bus_view         = alr_result_t'(result_bus_o);

  // The last-word antecedent already spans five of the settling cycles.
  localparam int SETTLE_LIM = SETTLE_CYC - 5;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  valid_tracks_a: assert property (
    result_valid == (cnt_q != '0))
    else $error("result_valid disagrees with pending count");

  last_word_a: assert property (
    (result_select && $rose(result_next) && (cnt_q == 5'h01) &&
     !lookup_valid) ##1 (!lookup_valid && result_select)[*4]
    |-> ##[0:SETTLE_LIM] !result_valid)
    else $error("result_valid not low after last word taken");

  more_words_a: assert property (
    port_pop && (cnt_q > 5'h01) |=> result_valid[*3])
    else $error("result_valid dropped with words remaining");

  no_select_a: assert property (
    (!result_select)[*3] |-> !port_pop)
    else $error("next strobe honoured without select");

  bus_enable_a: assert property (
    result_select[*3] |=> result_bus_oe)
    else $error("result bus not driven while selected");

  one_path_a: assert property (
    !(port_pop && host_pop))
    else $error("word delivered on both paths");

  head_word_a: assert property (
    push && (cnt_q == '0) |=> result_bus_o == $past(new_word))
    else $error("bus word differs from queued result");

  match_type_a: assert property (
    push && new_word.da_match |-> new_word.frame_type == ALR_TYPE_UCAST)
    else $error("match flag on non-unicast frame");

  same_port_a: assert property (
    push && new_word.same_port |->
    new_word.da_match && (new_word.dst_port == new_word.src_port))
    else $error("same-port flag without matching ports");

  host_pop_a: assert property (
    host_pop && !push |=> cnt_q == $past(cnt_q) - 5'h01)
    else $error("host read did not consume a word");

  irq_hold_a: assert property (
    irq_en_q && result_valid |-> !host_interrupt_n)
    else $error("interrupt released with words pending");

  push_count_a: assert property (
    push && !pop |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("accepted lookup result not queued");

  port_take_a: assert property (
    port_pop && !push |=> cnt_q == $past(cnt_q) - 5'h01)
    else $error("next strobe did not advance the queue");

  last_pop_a: assert property (
    port_pop && (cnt_q == 5'h01) && !push |=> !result_valid)
    else $error("result_valid high after last word taken");

  head_order_a: assert property (
    pop && (cnt_q > 5'h01) |=>
    result_bus_o == $past(mem_q[rd_ptr_q + 1'b1]))
    else $error("bus head not the next word in order");

  host_same_a: assert property (
    host_pop |=> host_rdata == $past(result_bus_o))
    else $error("host word differs from bus word");

  src_field_a: assert property (
    push && (cnt_q == '0) |=>
    bus_view.src_port == $past(lookup_res.src_port))
    else $error("receive port not carried to result word");

  type_field_a: assert property (
    push && (cnt_q == '0) |=>
    bus_view.frame_type == $past(lookup_res.frame_type))
    else $error("frame type not carried to result word");

  status_read_a: assert property (
    host_act && host_s2_q.write_n &&
    (host_s2_q.addr == OFF_RESULT_STATUS) |=>
    host_rdata[STAT_PEND_BIT] == ($past(cnt_q) != '0))
    else $error("status pending bit disagrees with queue");

  port_drain_c: cover property (port_pop ##[1:40] port_pop);
  host_drain_c: cover property (host_pop ##[1:40] host_pop);
  queue_full_c: cover property (cnt_q == DEPTH_CNT);
  collide_c:    cover property (port_pop && (hst_q == ALR_HOST_ACT));

endmodule

// file: hw/alr_pkg.sv
package alr_pkg;

  localparam int          WORD_W         = 16;
  localparam int          ADDR_W         = 8;
  localparam int          PORT_W         = 6;
  localparam int          DEPTH          = 16;
  localparam int          PTR_W          = 4;
  localparam int          CNT_W          = 5;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;

  // Host register offsets on the processor port.
  localparam logic [ADDR_W-1:0] OFF_RESULT_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RESULT_WORD   = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_RESULT_CTRL   = 8'h02;

  // Status and control field positions and reset values.
  localparam int               STAT_PEND_BIT  = 0;
  localparam int               STAT_CNT_LSB   = 8;
  localparam int               CTRL_IRQ_BIT   = 0;
  localparam logic             CTRL_IRQ_RST   = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST      = 16'h0000;

  // Settling time of result_valid after a next strobe.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_NS     = 140;
  localparam int SETTLE_CYC    = (SETTLE_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    ALR_TYPE_BCAST = 2'h0,
    ALR_TYPE_MCAST = 2'h1,
    ALR_TYPE_UCAST = 2'h2
  } alr_type_t;

  // Result word layout, identical on the bus and in the host register.
  typedef struct packed {
    logic [PORT_W-1:0] src_port;
    alr_type_t         frame_type;
    logic              da_match;
    logic [PORT_W-1:0] dst_port;
    logic              same_port;
  } alr_result_t;

  // Outcome of one frame's lookups, from the lookup engine.
  typedef struct packed {
    logic [PORT_W-1:0] src_port;
    alr_type_t         frame_type;
    logic              da_match;
    logic [PORT_W-1:0] dst_port;
  } alr_lookup_t;

  typedef struct packed {
    logic              cs_n;
    logic              write_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } alr_host_req_t;

  typedef enum logic [1:0] {
    ALR_HOST_IDLE = 2'b00,
    ALR_HOST_ACT  = 2'b01,
    ALR_HOST_HOLD = 2'b11
  } alr_host_state_t;

endpackage

// file: verification/alr_switch_model.sv
`timescale 1ns/1ps
module alr_switch_model
  import alr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              en,
  input  wire logic              slow,
  input  wire logic              stray,
  input  wire logic              result_valid,
  input  wire logic [WORD_W-1:0] result_bus,
  output logic                   result_select,
  output logic                   result_next,
  output logic [WORD_W-1:0]      got_word,
  output logic                   got_stb
);
  // Select stays up for the whole drain, as a lone device may tie it high.
  initial begin
    result_select = 1'b0;
    result_next   = 1'b0;
    got_stb       = 1'b0;
    got_word      = '0;
    forever begin
      @(posedge core_clk);
      #1 result_select = en;
      if (stray) begin
        result_next = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 result_next = 1'b0;
      end else if (en && result_valid) begin
        repeat (4) @(posedge core_clk);
        #1 got_word = result_bus;
        got_stb     = 1'b1;
        result_next = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 result_next = 1'b0;
        got_stb = 1'b0;
        // Next must sit low long enough for the next edge to count.
        repeat (slow ? 12 : 4) @(posedge core_clk);
      end
    end
  end
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import alr_pkg::*;
;
  logic              core_clk, rst, lookup_valid, lookup_ready;
  logic              result_select, result_next, result_bus_oe, result_valid;
  logic              host_data_oe, host_rdy, host_interrupt_n;
  logic              en, slow, stray, got_stb;
  logic [WORD_W-1:0] result_bus_o, bus_w, host_rdata, got_word, rd;
  logic [WORD_W-1:0] bus_last = '0;
  logic [WORD_W-1:0] exp_q[$];
  alr_lookup_t       lookup_res, lk;
  alr_host_req_t     host_req;
  int                n_fail, checks_done, cyc, seed;

  // An undriven bus shows the inverse of its last value, so the last driven word reappears every other cycle.
  assign bus_w = result_bus_oe ? result_bus_o : ~bus_last;
  always @(posedge core_clk) bus_last <= bus_w;

  alr_result_port alr_result_port_i (.core_clk, .rst, .lookup_valid,
    .lookup_res, .lookup_ready, .result_select, .result_next, .result_bus_o,
    .result_bus_oe, .result_valid, .host_req, .host_rdata, .host_data_oe,
    .host_rdy, .host_interrupt_n);
  alr_switch_model alr_switch_model_i (.core_clk, .en, .slow, .stray,
    .result_valid, .result_bus(bus_w), .result_select, .result_next,
    .got_word, .got_stb);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [WORD_W-1:0] seen,
                     input logic [WORD_W-1:0] e);
    checks_done++;
    if (seen !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [WORD_W-1:0] exp_word(input alr_lookup_t l);
    logic m;
    m = (l.frame_type == ALR_TYPE_UCAST) && l.da_match;
    return {l.src_port, l.frame_type, m, m ? l.dst_port : 6'h00,
            m && (l.dst_port == l.src_port)};
  endfunction

  function automatic logic [WORD_W-1:0] stat(input int n);
    return (WORD_W'(n) << STAT_CNT_LSB) | WORD_W'(n != 0);
  endfunction

  function automatic alr_lookup_t rand_lk();
    alr_lookup_t l;
    l = alr_lookup_t'(15'($random(seed)));
    if (l.frame_type == 2'h3) l.frame_type = ALR_TYPE_UCAST;
    return l;
  endfunction

  task automatic push(input alr_lookup_t l);
    int k;
    k = 0;
    @(posedge core_clk);
    #1 lookup_valid = 1'b1;
    lookup_res = l;
    do @(posedge core_clk); while (lookup_ready !== 1'b1 && ++k < 50);
    #1 lookup_valid = 1'b0;
    exp_q.push_back(exp_word(l));
  endtask

  task automatic host(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] wd,
                      output logic [WORD_W-1:0] r);
    int k;
    k = 0;
    host_req = '{cs_n: 1'b0, write_n: ~wr, addr: a, wdata: wd};
    do @(posedge core_clk); while (host_rdy !== 1'b1 && ++k < 100);
    r = host_rdata;
    chk(16'(host_data_oe), 16'(!wr));
    #1 host_req.cs_n = 1'b1;
    do @(posedge core_clk); while (host_rdy !== 1'b0 && ++k < 200);
    #1;
  endtask

  always @(posedge got_stb) chk(got_word, exp_q.pop_front());
  always @(posedge got_stb) chk(16'(result_bus_oe), 16'h1);

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    seed = 32'h92d5;
    {n_fail, checks_done, cyc} = '0;
    {rst, lookup_valid, en, slow, stray} = 5'h10;
    lookup_res = '0;
    host_req = '{cs_n: 1'b1, write_n: 1'b1, addr: 8'h00, wdata: 16'h0000};
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(16'(result_valid), 16'h0);
    chk(16'(host_interrupt_n), 16'h1);
    host(1'b0, OFF_RESULT_CTRL, 16'h0, rd);
    chk(rd, 16'(CTRL_IRQ_RST));
    for (int i = 0; i < 6; i++) begin
      lk = rand_lk();
      if (i < 3) begin
        lk.frame_type = alr_type_t'(i);
        lk.da_match = 1'b1;
        lk.dst_port = lk.src_port;
      end
      push(lk);
    end
    @(posedge core_clk);
    #1 chk(16'(result_valid), 16'h1);
    chk(16'(result_bus_oe), 16'h0);
    host(1'b0, OFF_RESULT_STATUS, 16'h0, rd);
    chk(rd, stat(6));
    host(1'b1, OFF_RESULT_CTRL, 16'h1, rd);
    chk(16'(host_interrupt_n), 16'h0);
    for (int i = 0; i < 6; i++) begin
      host(1'b0, OFF_RESULT_WORD, 16'h0, rd);
      chk(rd, exp_q.pop_front());
    end
    chk(16'(host_interrupt_n), 16'h1);
    chk(16'(result_valid), 16'h0);
    host(1'b0, OFF_RESULT_WORD, 16'h0, rd);
    chk(rd, 16'h0);
    host(1'b0, 8'h7f, 16'h0, rd);
    chk(rd, 16'h0);
    $display("test host_drain done");
    repeat (5) push(rand_lk());
    stray = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 stray = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 chk(16'(result_valid), 16'h1);
    host(1'b0, OFF_RESULT_STATUS, 16'h0, rd);
    chk(rd, stat(5));
    slow = 1'($random(seed));
    en = 1'b1;
    for (int k = 0; exp_q.size() > 0 && k < 3000; k++) begin
      chk(16'(result_valid), 16'h1);
      @(posedge core_clk);
      #1;
    end
    repeat (SETTLE_CYC) @(posedge core_clk);
    #1 chk(16'(result_valid), 16'h0);
    en = 1'b0;
    host(1'b0, OFF_RESULT_STATUS, 16'h0, rd);
    chk(rd, stat(0));
    $display("test port_drain done");
    repeat (DEPTH) push(rand_lk());
    @(posedge core_clk);
    #1 chk(16'(lookup_ready), 16'h0);
    host(1'b0, OFF_RESULT_STATUS, 16'h0, rd);
    chk(rd, stat(DEPTH));
    rst = 1'b1;
    exp_q.delete();
    @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(16'(result_valid), 16'h0);
    host(1'b0, OFF_RESULT_STATUS, 16'h0, rd);
    chk(rd, stat(0));
    $display("test fill_reset done");
    finish_test();
  end
endmodule
